/* core/sswd_regs.svh */
// Timing constants for the supply supervisor and watchdog.
// Assumes a 200 MHz system clock and a nominal 6.55 kHz slow oscillator.
`ifndef SSWD_REGS_SVH
`define SSWD_REGS_SVH

`define SSWD_CLK_HZ 200000000
`define SSWD_OSC_HZ 6550
`define SSWD_CYC_PER_TICK (`SSWD_CLK_HZ / `SSWD_OSC_HZ)
`define SSWD_RST_MS 50
`define SSWD_RST_LONG_MS 200
`define SSWD_WD_LONG_MS 1600
`define SSWD_WD_FAST_MS 100
`define SSWD_MS_TO_TICKS(ms) (((ms) * `SSWD_OSC_HZ) / 1000)
`define SSWD_CNT_W 16

`endif

/* core/sswd_pkg.sv */
// Types shared by the supply supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package sswd_pkg;

  // Gray along low -> stretch -> run
  typedef enum logic [1:0] {
    SSWD_S_LOW     = 2'b00,
    SSWD_S_STRETCH = 2'b01,
    SSWD_S_RUN     = 2'b11
  } sswd_state_t;

  typedef struct packed {
    logic supply_low;
    logic below_backup;
    logic pf_below;
    logic kick;
    logic kick_float;
  } sswd_sense_t;

endpackage

/* core/sswd_sync.sv */
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps
module sswd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

/* core/sswd_top.sv */
// Supply supervisor with reset stretch, watchdog, power-fail and CS gating.
// Assumes comparator results arrive as digital levels; slow oscillator derived from i_clk.
//
// What this block does
// - Reset output held low while supply is below threshold.
// - Reset stays low 50ms after supply recovers, 200ms on long variant.
// - Active-high reset output is always the inverse of active-low reset.
// - Power-fail flag low whenever power-fail sense is below reference.
// - Gated chip-select follows input when supply good, forced high otherwise.
// - Supply-low output low whenever supply is below reset threshold.
// - No kick for a full period gives a 50ms reset pulse, 200ms on long variant.
// - Without kicks, a new reset pulse follows every watchdog period.
// - Watchdog-expired output goes low on expiry until next kick.
// - Floating kick input disables the watchdog completely.
// - Backup-active output high while supply comes from backup.
// - Below backup supply, power-fail flag forced low.
// - Watchdog-expired output set high while supply-low is asserted.
// - Chip-select output forced high while supply below backup.
// - Long watchdog period after reset until the first kick.
`timescale 1ns/1ps
`include "sswd_regs.svh"
module sswd_top
  import sswd_pkg::*;
#(
  parameter int CYC_PER_TICK = `SSWD_CYC_PER_TICK,
  parameter int RST_TICKS = `SSWD_MS_TO_TICKS(`SSWD_RST_MS),
  parameter int RST_LONG_TICKS = `SSWD_MS_TO_TICKS(`SSWD_RST_LONG_MS),
  parameter int WD_LONG_TICKS = `SSWD_MS_TO_TICKS(`SSWD_WD_LONG_MS),
  parameter int WD_FAST_TICKS = `SSWD_MS_TO_TICKS(`SSWD_WD_FAST_MS)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Comparator results
  input wire logic i_supply_low,
  input wire logic i_below_backup,
  input wire logic i_pf_below,
  // Watchdog
  input wire logic i_watchdog_kick,
  input wire logic i_kick_float,
  // Configuration straps
  input wire logic i_timebase_input,
  input wire logic i_long_delay,
  // Chip-select gating
  input wire logic i_cs_n,
  output logic o_cs_n,
  // Processor side outputs
  output logic o_reset_n,
  output logic o_reset,
  output logic o_power_fail_flag_n,
  output logic o_supply_low_n,
  output logic o_watchdog_expired_n,
  output logic o_backup_active
);
  localparam int CW = `SSWD_CNT_W;
  localparam int TW = $clog2(CYC_PER_TICK + 1);

  sswd_sense_t sense_raw;
  sswd_sense_t sense_s;
  sswd_state_t state_r;
  sswd_state_t state_nxt;
  logic [TW-1:0] div_r;
  logic tick;
  logic [CW-1:0] st_cnt_r;
  logic [CW-1:0] wd_cnt_r;
  logic [CW-1:0] rst_end;
  logic [CW-1:0] wd_end;
  logic kick_prev_r;
  logic kick_edge;
  logic long_mode_r;
  logic wd_expire;
  logic stretch_done;

  assign sense_raw = '{
    supply_low: i_supply_low,
    below_backup: i_below_backup,
    pf_below: i_pf_below,
    kick: i_watchdog_kick,
    kick_float: i_kick_float
  };

  sswd_sync #(
    .W($bits(sswd_sense_t))
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(sense_raw),
    .o_q(sense_s)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      kick_prev_r <= 1'b0;
    end else begin
      kick_prev_r <= sense_s.kick;
    end
  end

  assign kick_edge = (sense_s.kick != kick_prev_r) && !sense_s.kick_float;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= '0;
    end else if (div_r == TW'(CYC_PER_TICK - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + TW'(1);
    end
  end

  assign tick = (div_r == TW'(CYC_PER_TICK - 1));

  // Straps are levels; end tests use >= so a shorter period chosen mid-count cannot overrun
  assign rst_end = i_long_delay ? CW'(RST_LONG_TICKS - 1) : CW'(RST_TICKS - 1);
  assign wd_end = (long_mode_r || i_timebase_input) ? CW'(WD_LONG_TICKS - 1)
                                                    : CW'(WD_FAST_TICKS - 1);

  assign stretch_done = tick && (st_cnt_r >= rst_end);

  assign wd_expire = (state_r == SSWD_S_RUN) && !sense_s.supply_low && !sense_s.kick_float &&
                     !kick_edge && tick && (wd_cnt_r >= wd_end);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SSWD_S_LOW: begin
        if (!sense_s.supply_low) begin
          state_nxt = SSWD_S_STRETCH;
        end
      end
      SSWD_S_STRETCH: begin
        if (sense_s.supply_low) begin
          state_nxt = SSWD_S_LOW;
        end else if (stretch_done) begin
          state_nxt = SSWD_S_RUN;
        end
      end
      SSWD_S_RUN: begin
        if (sense_s.supply_low) begin
          state_nxt = SSWD_S_LOW;
        end else if (wd_expire) begin
          state_nxt = SSWD_S_STRETCH;
        end
      end
      default: begin
        state_nxt = SSWD_S_LOW;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= SSWD_S_LOW;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_cnt_r <= '0;
    end else if (state_r != SSWD_S_STRETCH) begin
      st_cnt_r <= '0;
    end else if (tick) begin
      st_cnt_r <= st_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wd_cnt_r <= '0;
    end else if (state_r != SSWD_S_RUN || sense_s.kick_float || kick_edge) begin
      wd_cnt_r <= '0;
    end else if (tick) begin
      wd_cnt_r <= (wd_cnt_r >= wd_end) ? '0 : wd_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      long_mode_r <= 1'b1;
    end else if (state_r != SSWD_S_RUN) begin
      long_mode_r <= 1'b1;
    end else if (kick_edge) begin
      long_mode_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reset_n <= 1'b0;
      o_reset <= 1'b1;
    end else begin
      o_reset_n <= (state_nxt == SSWD_S_RUN);
      o_reset <= (state_nxt != SSWD_S_RUN);
    end
  end

  // expiry flag; clears win since expiry cannot coincide
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_watchdog_expired_n <= 1'b1;
    end else if (sense_s.supply_low || sense_s.kick_float || kick_edge) begin
      o_watchdog_expired_n <= 1'b1;
    end else if (wd_expire) begin
      o_watchdog_expired_n <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_power_fail_flag_n <= 1'b0;
    end else begin
      o_power_fail_flag_n <= !(sense_s.pf_below || sense_s.below_backup);
    end
  end

  // chip-select gate; costs one cycle of latency
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cs_n <= 1'b1;
    end else begin
      o_cs_n <= i_cs_n || sense_s.supply_low || sense_s.below_backup;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_supply_low_n <= 1'b0;
      o_backup_active <= 1'b0;
    end else begin
      o_supply_low_n <= !sense_s.supply_low;
      o_backup_active <= sense_s.below_backup;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_reset_low_supply: assert property (sense_s.supply_low |=> !o_reset_n)
    else $error("reset released while supply low");
  a_stretch_length: assert property (
    ($past(state_r) == SSWD_S_STRETCH) && $rose(o_reset_n) |->
      $past(st_cnt_r) >= $past(rst_end) && $past(tick))
    else $error("reset stretch wrong length");
  a_reset_inverse: assert property (o_reset == !o_reset_n)
    else $error("reset outputs not inverse");
  a_pf_flag_low: assert property (
    (sense_s.pf_below || sense_s.below_backup) |=> !o_power_fail_flag_n)
    else $error("power-fail flag not low");
  a_pf_flag_high: assert property (
    !i_rst && !sense_s.pf_below && !sense_s.below_backup |=> o_power_fail_flag_n)
    else $error("power-fail flag stuck low");
  a_cs_follow: assert property (
    !i_rst && !sense_s.supply_low && !sense_s.below_backup |=> o_cs_n == $past(i_cs_n))
    else $error("chip-select not following input");
  a_cs_forced: assert property (
    (sense_s.supply_low || sense_s.below_backup) |=> o_cs_n)
    else $error("chip-select not forced high");
  a_supply_low_out: assert property (
    !$past(i_rst) |-> o_supply_low_n == !$past(sense_s.supply_low))
    else $error("supply-low output wrong");
  a_backup_out: assert property (o_backup_active == $past(sense_s.below_backup))
    else $error("backup-active output wrong");
  a_expire_pulse: assert property (
    wd_expire |=> !o_reset_n && !o_watchdog_expired_n && state_r == SSWD_S_STRETCH)
    else $error("expiry did not start reset pulse");
  a_expiry_kick_clear: assert property (kick_edge |=> o_watchdog_expired_n)
    else $error("kick did not clear expiry flag");
  a_expiry_hold_low: assert property (
    !o_watchdog_expired_n && !kick_edge && !sense_s.supply_low && !sense_s.kick_float
      |=> !o_watchdog_expired_n)
    else $error("expiry flag released without kick");
  a_float_disable: assert property (sense_s.kick_float |-> !wd_expire ##1 o_watchdog_expired_n)
    else $error("watchdog active while kick floats");
  a_expiry_lowline: assert property (sense_s.supply_low |=> o_watchdog_expired_n)
    else $error("expiry flag low during supply low");
  a_long_after_rst: assert property (
    state_r == SSWD_S_RUN && $past(state_r) == SSWD_S_STRETCH |-> long_mode_r)
    else $error("long period not used after reset");
  a_wd_restart: assert property (state_r != SSWD_S_RUN |=> wd_cnt_r == '0)
    else $error("watchdog count not restarted");
  a_one_edge: assert property (kick_edge |=> !kick_edge)
    else $error("single toggle gave two edges");

  c_power_up: cover property (!o_reset_n ##1 o_reset_n);
  c_wd_expire: cover property (wd_expire);
  // Expiry while the flag is still low is a repeated pulse
  c_wd_repeat: cover property (wd_expire && !o_watchdog_expired_n);
  c_kick_service: cover property (kick_edge && long_mode_r);
endmodule

/* test/sswd_cpu.sv */
// Processor model: toggles the watchdog kick while told to run.
// Assumes the bench drives i_run and i_gap at rising edges.
`timescale 1ns/1ps
module sswd_cpu (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Control from bench
  input wire logic i_run,
  input wire logic [7:0] i_gap,
  // Kick line
  output logic o_kick
);
  logic [7:0] cnt_r;

  initial begin
    o_kick = 1'b0;
    cnt_r = 8'h00;
  end

  always @(posedge i_clk) begin
    if (!i_reset_n || !i_run) begin
      cnt_r <= 8'h00;
    end else if (cnt_r >= i_gap) begin
      cnt_r <= 8'h00;
      o_kick <= ~o_kick;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

/* test/sswd_top_tb.sv */
// Bench for the supply supervisor with a processor kick model.
// Assumes shortened tick parameters so the run stays small.
`timescale 1ns/1ps
module sswd_top_tb;
  localparam int C = 4;
  localparam int RT = 3;
  localparam int RL = 5;
  localparam int WL = 20;
  localparam int WF = 8;
  logic clk, rst, sl, bb, pf, kf, tb, ld, cs_n, run, kick;
  logic cso_n, rso_n, ra, pf_n, sl_n, wd_n, ba;
  logic [7:0] gap;
  logic [15:0] r;
  int n_mismatch, cmp_count, n, i;

  sswd_top #(.CYC_PER_TICK(C), .RST_TICKS(RT), .RST_LONG_TICKS(RL),
    .WD_LONG_TICKS(WL), .WD_FAST_TICKS(WF)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_supply_low(sl), .i_below_backup(bb),
    .i_pf_below(pf), .i_watchdog_kick(kick), .i_kick_float(kf),
    .i_timebase_input(tb), .i_long_delay(ld), .i_cs_n(cs_n), .o_cs_n(cso_n),
    .o_reset_n(rso_n), .o_reset(ra), .o_power_fail_flag_n(pf_n),
    .o_supply_low_n(sl_n), .o_watchdog_expired_n(wd_n), .o_backup_active(ba));
  sswd_cpu cpu_u (.i_clk(clk), .i_reset_n(rso_n), .i_run(run), .i_gap(gap),
    .o_kick(kick));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Tick phase is unknown, so spans get a tick of slack
  function automatic int lo(input int t);
    return (t - 1) * C;
  endfunction
  function automatic int hi(input int t);
    return (t + 1) * C + 6;
  endfunction

  task automatic chk(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int t);
    cmp_count++;
    if (g < lo(t) || g > hi(t)) begin
      n_mismatch++;
      $display("[FAIL] %0t span %0d for %0d ticks", $time, g, t);
    end
  endtask
  task automatic wt(input logic v, output int c);
    c = 0;
    while (rso_n !== v && c < 2000) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rst, sl, bb, pf, kf, tb, ld, cs_n, run} = 9'h101;
    gap = 8'h0a;
    r = 16'hbf04;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rst <= 0;
    wt(1, n);
    chk_n(n, RT);
    @(posedge clk);
    run <= 1;
    for (i = 0; i < 24; i++) begin
      r = lfsr(r);
      @(posedge clk);
      cs_n <= r[0];
      pf <= r[1];
      bb <= r[2] & r[3];
      repeat (4) @(negedge clk);
      chk(cso_n, r[0] | (r[2] & r[3]));
      chk(pf_n, ~(r[1] | (r[2] & r[3])));
      chk(ba, r[2] & r[3]);
      chk(ra, ~rso_n);
    end
    // Stop just after a kick so the fast period is measured whole
    @(kick);
    @(posedge clk);
    run <= 0;
    bb <= 0;
    wt(0, n);
    chk_n(n, WF);
    chk(wd_n, 0);
    wt(1, n);
    chk_n(n, RT);
    wt(0, n);
    chk_n(n, WL);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      ld <= i[0];
      sl <= 1;
      cs_n <= 0;
      repeat (4) @(negedge clk);
      chk(rso_n, 0);
      chk(sl_n, 0);
      chk(cso_n, 1);
      chk(wd_n, 1);
      chk(ra, 1);
      @(posedge clk);
      sl <= 0;
      wt(1, n);
      chk_n(n, i ? RL : RT);
      chk(sl_n, 1);
    end
    wt(0, n);
    chk_n(n, WL);
    chk(wd_n, 0);
    wt(1, n);
    @(posedge clk);
    run <= 1;
    repeat (60) @(negedge clk);
    chk(wd_n, 1);
    chk(rso_n, 1);
    // Slow timebase keeps the long period after a kick
    @(posedge clk);
    tb <= 1;
    @(kick);
    @(posedge clk);
    run <= 0;
    wt(0, n);
    chk_n(n, WL);
    chk(wd_n, 0);
    wt(1, n);
    chk_n(n, RL);
    @(posedge clk);
    kf <= 1;
    repeat (200) @(negedge clk);
    chk(rso_n, 1);
    chk(wd_n, 1);
    report_and_stop();
  end
endmodule
